// [design/spir_fifo.sv]
// Transmit byte FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module spir_fifo
  import spir_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("spir_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
  logic [AW:0] count_ff, nxt_count;
  logic ovalid_ff, nxt_ovalid;
  logic [WIDTH-1:0] odata_ff, nxt_odata;
  logic push, pull;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = ovalid_ff;
  assign out_data = odata_ff;
  assign push = in_valid && in_ready;
  // Output stage refills as soon as it empties or is taken
  assign pull = (count_ff != '0) && (!ovalid_ff || out_ready);

  always_comb
  begin
    nxt_wptr = push ? wptr_ff + 1'b1 : wptr_ff;
    nxt_rptr = pull ? rptr_ff + 1'b1 : rptr_ff;
    nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pull);
    nxt_odata = pull ? mem[rptr_ff] : odata_ff;
    nxt_ovalid = pull ? 1'b1 : (out_ready ? 1'b0 : ovalid_ff);
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr_ff] <= in_data;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
      ovalid_ff <= 1'b0;
      odata_ff <= '0;
    end
    else
    begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      count_ff <= nxt_count;
      ovalid_ff <= nxt_ovalid;
      odata_ff <= nxt_odata;
    end
  end

endmodule
`default_nettype wire

// [design/spir_regs.sv]
// Pot scan strobe, serial data and interrupt enable register bank
`timescale 1ns/1ps
`default_nettype none
module spir_regs
  import spir_pkg::*;
#(
  parameter int BIT_CLKS = 16,
  parameter int FIFO_DEPTH = 16
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire spir_bus_req_t BUS_REQ,
  output logic [7:0] BUS_RDATA,
  input wire logic FAST_SCAN,
  input wire logic [NUM_POTS-1:0] PADDLE_IN,
  output logic POT_DUMP,
  output spir_pot_vals_t PADDLE_RESULT,
  output logic [NUM_POTS-1:0] PADDLE_BUSY_MASK,
  input wire logic SER_IN,
  output logic SER_OUT,
  output logic TX_FIFO_READY,
  input wire logic [NUM_IRQ-1:0] SRC_EVENT,
  output logic [NUM_IRQ-1:0] IRQ_SOURCE_ENABLE,
  output logic [NUM_IRQ-1:0] INTERRUPT_STATUS,
  output logic IRQ_N,
  output logic RX_OVERRUN,
  input wire logic ERR_CLEAR
);

  localparam int BW = $clog2(BIT_CLKS + 1);
  localparam int DW = $clog2(POT_SLOW_DIV);

  initial
  begin
    if (BIT_CLKS < 4)
      $error("spir_regs: BIT_CLKS must be at least 4");
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_pot, wr_tx, wr_en, rd_rx;

  assign wr_pot = BUS_REQ.sel && BUS_REQ.wr && (BUS_REQ.addr == ADDR_POT_SCAN_START);
  assign wr_tx = BUS_REQ.sel && BUS_REQ.wr && (BUS_REQ.addr == ADDR_SERIAL_DATA);
  assign wr_en = BUS_REQ.sel && BUS_REQ.wr && (BUS_REQ.addr == ADDR_IRQ_SOURCE_ENABLE);
  assign rd_rx = BUS_REQ.sel && BUS_REQ.rd && (BUS_REQ.addr == ADDR_SERIAL_DATA);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_POTS:0] sync1_ff, sync2_ff;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end
    else
    begin
      sync1_ff <= {SER_IN, PADDLE_IN};
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Paddle scan
  // ----------------------------------------------------------------
  logic [DW-1:0] div_ff, nxt_div;
  logic [7:0] cnt_ff, nxt_cnt;
  logic dump_ff, nxt_dump;
  logic tick;

  // Slow scan steps once per line period, fast scan every cycle
  assign tick = FAST_SCAN || (div_ff == DW'(POT_SLOW_DIV - 1));

  always_comb
  begin
    nxt_div = (tick || wr_pot) ? '0 : div_ff + 1'b1;
    nxt_dump = wr_pot;
    nxt_cnt = cnt_ff;
    if (wr_pot)
      nxt_cnt = '0;
    else if (tick && cnt_ff != POT_COUNT_MAX)
      nxt_cnt = cnt_ff + 1'b1;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      div_ff <= '0;
      cnt_ff <= '0;
      dump_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      dump_ff <= nxt_dump;
    end
  end

  assign POT_DUMP = dump_ff;

  genvar p;
  generate
    for (p = 0; p < NUM_POTS; p++)
    begin : g_pot
      logic [7:0] res_ff, nxt_res;
      logic busy_ff, nxt_busy;

      always_comb
      begin
        nxt_res = res_ff;
        nxt_busy = busy_ff;
        if (wr_pot)
        begin
          nxt_res = POT_RESULT_CLR;
          nxt_busy = POT_BUSY_SET[p];
        end
        else if (busy_ff && (sync2_ff[p] || cnt_ff == POT_COUNT_MAX))
        begin
          // Capacitor charged or count ran out: measurement ends
          nxt_res = cnt_ff;
          nxt_busy = 1'b0;
        end
      end

      always_ff @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          res_ff <= POT_RESULT_CLR;
          busy_ff <= 1'b0;
        end
        else
        begin
          res_ff <= nxt_res;
          busy_ff <= nxt_busy;
        end
      end

      assign PADDLE_RESULT[p] = res_ff;
      assign PADDLE_BUSY_MASK[p] = busy_ff;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic f_valid, f_ready;
  logic [7:0] f_data;
  spir_tx_state_t tx_st_ff, nxt_tx_st;
  logic [SER_FRAME_BITS-1:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_bits_ff, nxt_tx_bits;
  logic [BW-1:0] tx_tmr_ff, nxt_tx_tmr;
  logic tx_out_ff, nxt_tx_out;
  logic tx_load, tx_idle;

  // Writes while the FIFO is full are dropped; TX_FIFO_READY warns the source
  spir_fifo #(.WIDTH(SER_DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rstn(RSTN),
    .in_valid(wr_tx),
    .in_ready(TX_FIFO_READY),
    .in_data(BUS_REQ.wdata),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  assign tx_load = (tx_st_ff == TX_IDLE) && f_valid;
  assign f_ready = tx_load;
  assign tx_idle = (tx_st_ff == TX_IDLE) && !f_valid;

  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_bits = tx_bits_ff;
    nxt_tx_tmr = tx_tmr_ff;
    nxt_tx_out = tx_out_ff;
    case (tx_st_ff)
      TX_IDLE:
      begin
        nxt_tx_out = 1'b1;
        if (tx_load)
        begin
          nxt_tx_sh = {1'b1, f_data, 1'b0};
          nxt_tx_bits = 4'(SER_FRAME_BITS);
          nxt_tx_tmr = '0;
          nxt_tx_st = TX_SHIFT;
        end
      end
      TX_SHIFT:
      begin
        if (tx_tmr_ff == '0)
        begin
          if (tx_bits_ff == '0)
            nxt_tx_st = TX_IDLE;
          else
          begin
            nxt_tx_out = tx_sh_ff[0];
            nxt_tx_sh = {1'b1, tx_sh_ff[SER_FRAME_BITS-1:1]};
            nxt_tx_bits = tx_bits_ff - 1'b1;
            nxt_tx_tmr = BW'(BIT_CLKS - 1);
          end
        end
        else
          nxt_tx_tmr = tx_tmr_ff - 1'b1;
      end
      default:
        nxt_tx_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= '1;
      tx_bits_ff <= '0;
      tx_tmr_ff <= '0;
      tx_out_ff <= 1'b1;
    end
    else
    begin
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_bits_ff <= nxt_tx_bits;
      tx_tmr_ff <= nxt_tx_tmr;
      tx_out_ff <= nxt_tx_out;
    end
  end

  assign SER_OUT = tx_out_ff;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  spir_rx_state_t rx_st_ff, nxt_rx_st;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic [7:0] rx_data_ff, nxt_rx_data;
  logic [3:0] rx_bits_ff, nxt_rx_bits;
  logic [BW-1:0] rx_tmr_ff, nxt_rx_tmr;
  logic rx_rdy_ff, nxt_rx_rdy;
  logic ovr_ff, nxt_ovr;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rx_done;
  logic rx_line;

  assign rx_line = sync2_ff[NUM_POTS];

  always_comb
  begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_bits = rx_bits_ff;
    nxt_rx_tmr = (rx_tmr_ff == '0) ? '0 : rx_tmr_ff - 1'b1;
    rx_done = 1'b0;
    case (rx_st_ff)
      RX_IDLE:
      begin
        if (!rx_line)
        begin
          nxt_rx_tmr = BW'(BIT_CLKS / 2);
          nxt_rx_st = RX_START;
        end
      end
      RX_START:
      begin
        if (rx_tmr_ff == '0)
        begin
          nxt_rx_st = rx_line ? RX_IDLE : RX_DATA;
          nxt_rx_tmr = BW'(BIT_CLKS - 1);
          nxt_rx_bits = '0;
        end
      end
      RX_DATA:
      begin
        if (rx_tmr_ff == '0)
        begin
          nxt_rx_sh = {rx_line, rx_sh_ff[7:1]};
          nxt_rx_bits = rx_bits_ff + 1'b1;
          nxt_rx_tmr = BW'(BIT_CLKS - 1);
          if (rx_bits_ff == 4'(SER_DATA_BITS - 1))
            nxt_rx_st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (rx_tmr_ff == '0)
        begin
          rx_done = 1'b1;
          nxt_rx_st = RX_IDLE;
        end
      end
      default:
        nxt_rx_st = RX_IDLE;
    endcase
    nxt_rx_data = rx_done ? rx_sh_ff : rx_data_ff;
    // Arrival wins over a read in the same cycle
    nxt_rx_rdy = rx_done ? 1'b1 : (rd_rx ? 1'b0 : rx_rdy_ff);
    // Overrun follows the pending interrupt, not the read state
    nxt_ovr = (rx_done && INTERRUPT_STATUS[IRQ_BIT_RX_READY]) ? 1'b1 : (ERR_CLEAR ? 1'b0 : ovr_ff);
    nxt_rdata = rd_rx ? rx_data_ff : RDATA_UNMAPPED;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_st_ff <= RX_IDLE;
      rx_sh_ff <= SER_DATA_RST;
      rx_data_ff <= SER_DATA_RST;
      rx_bits_ff <= '0;
      rx_tmr_ff <= '0;
      rx_rdy_ff <= 1'b0;
      ovr_ff <= 1'b0;
      rdata_ff <= RDATA_UNMAPPED;
    end
    else
    begin
      rx_st_ff <= nxt_rx_st;
      rx_sh_ff <= nxt_rx_sh;
      rx_data_ff <= nxt_rx_data;
      rx_bits_ff <= nxt_rx_bits;
      rx_tmr_ff <= nxt_rx_tmr;
      rx_rdy_ff <= nxt_rx_rdy;
      ovr_ff <= nxt_ovr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign BUS_RDATA = rdata_ff;
  assign RX_OVERRUN = ovr_ff;

  // ----------------------------------------------------------------
  // Interrupt enable and status
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] en_ff, nxt_en, st_ff, nxt_st, ev;

  always_comb
  begin
    nxt_en = wr_en ? BUS_REQ.wdata : en_ff;
    ev = SRC_EVENT;
    ev[IRQ_BIT_RX_READY] = rx_done;
    ev[IRQ_BIT_TX_EMPTY] = tx_load;
    ev[IRQ_BIT_TX_DONE] = 1'b0;
  end

  genvar i;
  generate
    for (i = 0; i < NUM_IRQ; i++)
    begin : g_irq
      if (i == IRQ_BIT_TX_DONE)
      begin : g_level
        // Not latched; tracks tx_idle, and an enable write clearing the bit clears it
        assign nxt_st[i] = nxt_en[i] && tx_idle;
      end
      else
      begin : g_latch
        // Disable clears pending state; events count only while enabled
        assign nxt_st[i] = nxt_en[i] && (st_ff[i] || ev[i]);
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      en_ff <= IRQ_ENABLE_RST;
      st_ff <= '0;
    end
    else
    begin
      en_ff <= nxt_en;
      st_ff <= nxt_st;
    end
  end

  assign IRQ_SOURCE_ENABLE = en_ff;
  assign INTERRUPT_STATUS = st_ff;
  assign IRQ_N = ~|st_ff;

endmodule
`default_nettype wire

// [shared/spir_pkg.sv]
// Shared constants and types for the serial, paddle and interrupt register bank
package spir_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_POT_SCAN_START = 16'hd20b;
  localparam logic [15:0] ADDR_SERIAL_DATA = 16'hd20d;
  localparam logic [15:0] ADDR_IRQ_SOURCE_ENABLE = 16'hd20e;

  // ----------------------------------------------------------------
  // Interrupt source bit positions
  // ----------------------------------------------------------------
  localparam int IRQ_BIT_BREAK_KEY = 7;
  localparam int IRQ_BIT_KEYBOARD = 6;
  localparam int IRQ_BIT_RX_READY = 5;
  localparam int IRQ_BIT_TX_EMPTY = 4;
  localparam int IRQ_BIT_TX_DONE = 3;
  localparam int IRQ_BIT_TIMER_FOUR = 2;
  localparam int IRQ_BIT_TIMER_TWO = 1;
  localparam int IRQ_BIT_TIMER_ONE = 0;
  localparam int NUM_IRQ = 8;

  // ----------------------------------------------------------------
  // Reset and restart values
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] POT_RESULT_CLR = 8'h00;
  localparam logic [7:0] POT_BUSY_SET = 8'hff;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam logic [7:0] SER_DATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int POT_SLOW_DIV = 114;
  localparam logic [7:0] POT_COUNT_MAX = 8'he4;
  localparam int NUM_POTS = 8;
  localparam int SER_DATA_BITS = 8;
  localparam int SER_FRAME_BITS = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } spir_bus_req_t;

  typedef logic [NUM_POTS-1:0][7:0] spir_pot_vals_t;

  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} spir_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spir_rx_state_t;

endpackage

// [verif/spir_periph.sv]
// Serial bus peripheral model: frame sender and receiver
`timescale 1ns/1ps
`default_nettype none
module spir_periph
#(
  parameter int BIT_CLKS = 4
)
(
  input wire logic clk,
  input wire logic ser_out,
  output logic ser_in
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  // Line rests high between frames, as with a pull-up
  initial ser_in = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      ser_in <= fr[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
  // Samples mid-bit on the falling edge, away from the line's update
  initial
  begin
    forever
    begin
      @(negedge clk);
      if (ser_out === 1'b0)
      begin
        repeat (BIT_CLKS / 2) @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CLKS) @(negedge clk);
          sh[i] = ser_out;
        end
        repeat (BIT_CLKS) @(negedge clk);
        got_q.push_back(sh);
      end
    end
  end
endmodule
`default_nettype wire

// [verif/spir_regs_sva.sv]
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module spir_regs_chk
  import spir_pkg::*;
#(
  parameter int BIT_CLKS = 16
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire spir_bus_req_t BUS_REQ,
  input wire logic [7:0] BUS_RDATA,
  input wire logic POT_DUMP,
  input wire spir_pot_vals_t PADDLE_RESULT,
  input wire logic [NUM_POTS-1:0] PADDLE_BUSY_MASK,
  input wire logic SER_OUT,
  input wire logic [NUM_IRQ-1:0] SRC_EVENT,
  input wire logic [NUM_IRQ-1:0] IRQ_SOURCE_ENABLE,
  input wire logic [NUM_IRQ-1:0] INTERRUPT_STATUS,
  input wire logic RX_OVERRUN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire logic wr = BUS_REQ.sel && BUS_REQ.wr;
  wire logic wr_pot = wr && BUS_REQ.addr == ADDR_POT_SCAN_START;
  wire logic wr_tx = wr && BUS_REQ.addr == ADDR_SERIAL_DATA;
  wire logic wr_en = wr && BUS_REQ.addr == ADDR_IRQ_SOURCE_ENABLE;
  wire logic rd_rx = BUS_REQ.sel && BUS_REQ.rd && BUS_REQ.addr == ADDR_SERIAL_DATA;
  logic [7:0] ev_ff;
  logic [7:0] idle_ff;
  // Idle only once the line has rested longer than the longest high run inside a frame
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ev_ff <= 8'h00;
      idle_ff <= 8'h00;
    end
    else
    begin
      ev_ff <= wr_en ? 8'h00 : (SRC_EVENT & IRQ_SOURCE_ENABLE & 8'hc7);
      if (!SER_OUT || wr_tx)
        idle_ff <= 8'h00;
      else if (idle_ff != 8'hff)
        idle_ff <= idle_ff + 8'h01;
    end
  end
  // ----
  // Properties
  // ----
  property p_restart;
    wr_pot |=> POT_DUMP && PADDLE_BUSY_MASK == POT_BUSY_SET && PADDLE_RESULT == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missing");
  property p_dump_cause;
    POT_DUMP |-> $past(wr_pot);
  endproperty
  a_dump_cause: assert property (p_dump_cause) else $error("stray dump");
  property p_busy_rise;
    |(PADDLE_BUSY_MASK & ~$past(PADDLE_BUSY_MASK)) |-> POT_DUMP;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy without restart");
  property p_en_load;
    wr_en |=> IRQ_SOURCE_ENABLE == $past(BUS_REQ.wdata);
  endproperty
  a_en_load: assert property (p_en_load) else $error("enable not loaded");
  property p_en_clear;
    wr_en |=> (INTERRUPT_STATUS & ~$past(BUS_REQ.wdata) & 8'hf7) == 8'h00;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("status not cleared");
  property p_latch;
    ev_ff != 8'h00 |-> (INTERRUPT_STATUS & ev_ff) == ev_ff;
  endproperty
  a_latch: assert property (p_latch) else $error("event lost");
  property p_tx_done;
    wr_en && BUS_REQ.wdata[IRQ_BIT_TX_DONE] && idle_ff >= 10 * BIT_CLKS + 4
      |-> ##[1:2] INTERRUPT_STATUS[IRQ_BIT_TX_DONE];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("idle tx irq missing");
  property p_rdata;
    !rd_rx |=> BUS_RDATA == RDATA_UNMAPPED;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data leak");
  property p_ovr;
    $rose(RX_OVERRUN) |-> $past(INTERRUPT_STATUS[IRQ_BIT_RX_READY]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun without pending rx");
  c_restart: cover property (wr_pot);
  c_ovr: cover property ($rose(RX_OVERRUN));
  c_tx_done: cover property ($rose(INTERRUPT_STATUS[IRQ_BIT_TX_DONE]));
endmodule
bind spir_regs spir_regs_chk #(.BIT_CLKS(BIT_CLKS)) i_chk (.CLK(CLK), .RSTN(RSTN), .BUS_REQ(BUS_REQ),
  .BUS_RDATA(BUS_RDATA), .POT_DUMP(POT_DUMP), .PADDLE_RESULT(PADDLE_RESULT),
  .PADDLE_BUSY_MASK(PADDLE_BUSY_MASK), .SER_OUT(SER_OUT), .SRC_EVENT(SRC_EVENT),
  .IRQ_SOURCE_ENABLE(IRQ_SOURCE_ENABLE), .INTERRUPT_STATUS(INTERRUPT_STATUS), .RX_OVERRUN(RX_OVERRUN));
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import spir_pkg::*;
;
  localparam int BC = 4;
  logic CLK, RSTN, FAST_SCAN, SER_IN, SER_OUT, TX_FIFO_READY, POT_DUMP, IRQ_N, RX_OVERRUN, ERR_CLEAR;
  spir_bus_req_t BUS_REQ;
  logic [7:0] BUS_RDATA, PADDLE_IN, PADDLE_BUSY_MASK, SRC_EVENT, IRQ_SOURCE_ENABLE, INTERRUPT_STATUS;
  spir_pot_vals_t PADDLE_RESULT;
  int error_cnt, compares;
  spir_regs #(.BIT_CLKS(BC), .FIFO_DEPTH(16)) i_dut (.CLK(CLK), .RSTN(RSTN), .BUS_REQ(BUS_REQ),
    .BUS_RDATA(BUS_RDATA), .FAST_SCAN(FAST_SCAN), .PADDLE_IN(PADDLE_IN), .POT_DUMP(POT_DUMP),
    .PADDLE_RESULT(PADDLE_RESULT), .PADDLE_BUSY_MASK(PADDLE_BUSY_MASK), .SER_IN(SER_IN), .SER_OUT(SER_OUT),
    .TX_FIFO_READY(TX_FIFO_READY), .SRC_EVENT(SRC_EVENT), .IRQ_SOURCE_ENABLE(IRQ_SOURCE_ENABLE),
    .INTERRUPT_STATUS(INTERRUPT_STATUS), .IRQ_N(IRQ_N), .RX_OVERRUN(RX_OVERRUN), .ERR_CLEAR(ERR_CLEAR));
  spir_periph #(.BIT_CLKS(BC)) i_per (.clk(CLK), .ser_out(SER_OUT), .ser_in(SER_IN));
  initial
  begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // ----
  // Shared tasks
  // ----
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
    summarize();
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK);
    BUS_REQ <= {1'b1, 1'b1, 1'b0, a, d};
    @(posedge CLK);
    BUS_REQ <= '0;
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge CLK);
    BUS_REQ <= {1'b1, 1'b0, 1'b1, a, 8'h00};
    @(posedge CLK);
    BUS_REQ <= '0;
    #1;
    d = BUS_RDATA;
  endtask
  task automatic wait_st(input int b);
    int i;
    for (i = 0; i < 200 && INTERRUPT_STATUS[b] !== 1'b1; i++)
      @(negedge CLK);
    if (i == 200)
      fail("status wait");
  endtask
  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 4000 && i_per.got_q.size() < n; i++)
      @(negedge CLK);
    if (i == 4000)
      fail("serial wait");
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_refused();
    logic [7:0] d;
    logic [15:0] ad[3] = '{ADDR_POT_SCAN_START, ADDR_IRQ_SOURCE_ENABLE, 16'hd20c};
    chk({IRQ_SOURCE_ENABLE, INTERRUPT_STATUS, IRQ_N, SER_OUT, TX_FIFO_READY}, {16'h0000, 3'b111}, "reset");
    foreach (ad[k])
    begin
      bus_rd(ad[k], d);
      chk(d, 8'h00, "read refused");
    end
    bus_wr(16'hd20f, 8'hff);
    #1;
    chk(IRQ_SOURCE_ENABLE, 8'h00, "unmapped write");
    $display("test refused done");
  endtask
  task automatic t_irq();
    int bits[5] = '{7, 6, 2, 1, 0};
    logic [7:0] m;
    foreach (bits[k])
    begin
      m = 8'h01 << bits[k];
      bus_wr(ADDR_IRQ_SOURCE_ENABLE, m);
      @(posedge CLK);
      SRC_EVENT <= 8'hc7;
      @(posedge CLK);
      SRC_EVENT <= 8'h00;
      #1;
      chk({IRQ_SOURCE_ENABLE, INTERRUPT_STATUS, IRQ_N}, {m, m, 1'b0}, "irq set");
      bus_wr(ADDR_IRQ_SOURCE_ENABLE, 8'h00);
      #1;
      chk({INTERRUPT_STATUS, IRQ_N}, {8'h00, 1'b1}, "irq clear");
    end
    $display("test irq done");
  endtask
  task automatic t_pot();
    int i;
    bus_wr(ADDR_POT_SCAN_START, 8'h5a);
    #1;
    chk({POT_DUMP, PADDLE_BUSY_MASK}, {1'b1, POT_BUSY_SET}, "restart");
    chk(PADDLE_RESULT, '0, "results cleared");
    repeat (20) @(posedge CLK);
    PADDLE_IN <= 8'h08;
    for (i = 0; i < 50 && PADDLE_BUSY_MASK[3] !== 1'b0; i++)
      @(negedge CLK);
    if (i == 50)
      fail("pot wait");
    chk(PADDLE_BUSY_MASK, 8'hf7, "one pot done");
    chk(PADDLE_RESULT[3] > 8'h10 && PADDLE_RESULT[3] < 8'h20, 1'b1, "pot count");
    bus_wr(ADDR_POT_SCAN_START, 8'h00);
    #1;
    chk({PADDLE_BUSY_MASK, PADDLE_RESULT[3]}, {POT_BUSY_SET, 8'h00}, "restart mid");
    @(posedge CLK);
    FAST_SCAN <= 1'b0;
    PADDLE_IN <= 8'hff;
    repeat (6) @(negedge CLK);
    chk(PADDLE_BUSY_MASK, 8'h00, "all pots done");
    chk(PADDLE_RESULT[0] < 8'h02, 1'b1, "slow scan");
    $display("test pot done");
  endtask
  task automatic t_tx();
    i_per.got_q.delete();
    bus_wr(ADDR_IRQ_SOURCE_ENABLE, 8'h18);
    repeat (2) @(negedge CLK);
    chk({INTERRUPT_STATUS, IRQ_N}, {8'h08, 1'b0}, "idle tx irq");
    bus_wr(ADDR_SERIAL_DATA, 8'h81);
    repeat (6) @(negedge CLK);
    chk(INTERRUPT_STATUS[3], 1'b0, "tx busy");
    chk(INTERRUPT_STATUS[4], 1'b1, "tx need");
    wait_rx(1);
    chk(i_per.got_q[0], 8'h81, "tx byte");
    repeat (2 * BC) @(negedge CLK);
    chk(INTERRUPT_STATUS[3], 1'b1, "tx idle again");
    bus_wr(ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    $display("test tx done");
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    i_per.got_q.delete();
    while (n < 40 && TX_FIFO_READY === 1'b1)
    begin
      bus_wr(ADDR_SERIAL_DATA, 8'h30 + n[7:0]);
      n++;
      #1;
    end
    chk(n > 15 && n < 40, 1'b1, "fifo refuses");
    wait_rx(n);
    foreach (i_per.got_q[k])
      chk(i_per.got_q[k], 8'h30 + k[7:0], "fifo order");
    chk(TX_FIFO_READY, 1'b1, "fifo drained");
    $display("test fill done");
  endtask
  task automatic t_rx();
    logic [7:0] d;
    bus_wr(ADDR_IRQ_SOURCE_ENABLE, 8'h20);
    i_per.send_byte(8'h5a);
    wait_st(5);
    i_per.send_byte(8'ha5);
    repeat (2 * BC) @(negedge CLK);
    chk(RX_OVERRUN, 1'b1, "overrun");
    bus_rd(ADDR_SERIAL_DATA, d);
    chk(d, 8'ha5, "overwrite");
    @(posedge CLK);
    ERR_CLEAR <= 1'b1;
    @(posedge CLK);
    ERR_CLEAR <= 1'b0;
    bus_wr(ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    bus_wr(ADDR_IRQ_SOURCE_ENABLE, 8'h20);
    i_per.send_byte(8'h3c);
    wait_st(5);
    chk(RX_OVERRUN, 1'b0, "no overrun");
    bus_rd(ADDR_SERIAL_DATA, d);
    chk(d, 8'h3c, "rx byte");
    i_per.send_byte(8'h69);
    repeat (2 * BC) @(negedge CLK);
    chk(RX_OVERRUN, 1'b1, "overrun after read");
    bus_wr(ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    $display("test rx done");
  endtask
  initial
  begin
    RSTN = 1'b0;
    BUS_REQ = '0;
    FAST_SCAN = 1'b1;
    PADDLE_IN = 8'h00;
    SRC_EVENT = 8'h00;
    ERR_CLEAR = 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    t_refused();
    t_irq();
    t_pot();
    t_tx();
    t_fill();
    t_rx();
    summarize();
  end
endmodule
`default_nettype wire
